/* File: core/shbi_chan.sv */
// one serial channel: transmitter with holding register, receiver
`timescale 1ns/1ps
module shbi_chan
  import shbi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic tick16,
  input wire shbi_chan_cfg_t cfg,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  input wire logic rx_take,
  input wire logic err_clr,
  input wire logic serial_in,
  output logic serial_out,
  output shbi_chan_sts_t sts,
  output logic [7:0] rx_byte
);
  shbi_ser_state_t tst_q, tst_d, rst_q, rst_d;
  logic [7:0] hold_q, hold_d, tsh_q, tsh_d, rsh_q, rsh_d, rdat_q, rdat_d;
  logic hold_full_q, hold_full_d, line_q, line_d, tx_line, rx_src;
  logic [3:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [2:0] tbit_q, tbit_d, rbit_q, rbit_d, last_bit;
  logic rfull_q, rfull_d, ovr_q, ovr_d, fre_q, fre_d;

  always_comb begin
    last_bit = 3'(3'h4 + {1'b0, cfg.len});
    // serial_in and the transmitter idle high as mark, low is space
    tx_line = (tst_q == SER_START) ? 1'b0 :
              (tst_q == SER_DATA) ? tsh_q[0] : 1'b1;
    rx_src = cfg.loop ? tx_line : serial_in;
    tst_d = tst_q;
    hold_d = hold_q;
    hold_full_d = hold_full_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    case (tst_q)
      SER_IDLE: begin
        if (hold_full_q && cfg.tx_en) begin
          tsh_d = hold_q;
          hold_full_d = 1'b0;
          tcnt_d = 4'h0;
          tst_d = SER_START;
        end
      end
      SER_START: begin
        if (tick16) begin
          tcnt_d = tcnt_q + 4'h1;
          if (tcnt_q == 4'hF) begin
            tbit_d = 3'h0;
            tst_d = SER_DATA;
          end
        end
      end
      SER_DATA: begin
        if (tick16) begin
          tcnt_d = tcnt_q + 4'h1;
          if (tcnt_q == 4'hF) begin
            tsh_d = {1'b1, tsh_q[7:1]};
            tbit_d = tbit_q + 3'h1;
            if (tbit_q == last_bit) tst_d = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (tick16) begin
          tcnt_d = tcnt_q + 4'h1;
          if (tcnt_q == 4'hF) tst_d = SER_IDLE;
        end
      end
      default: tst_d = SER_IDLE;
    endcase
    if (tx_load) begin
      hold_d = tx_byte;
      hold_full_d = 1'b1;
    end
    // mark while idle or looped back; disabling does not cut a frame under way short
    line_d = cfg.loop ? 1'b1 : tx_line;

    rst_d = rst_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rdat_d = rdat_q;
    rfull_d = rx_take ? 1'b0 : rfull_q;
    ovr_d = err_clr ? 1'b0 : ovr_q;
    fre_d = err_clr ? 1'b0 : fre_q;
    case (rst_q)
      SER_IDLE: begin
        if (tick16 && cfg.rx_en && !rx_src) begin
          rcnt_d = 4'h0;
          rst_d = SER_START;
        end
      end
      SER_START: begin
        if (tick16) begin
          rcnt_d = rcnt_q + 4'h1;
          if (rcnt_q == 4'h7) begin
            // a start bit gone high at mid-bit is a false start
            rst_d = rx_src ? SER_IDLE : SER_DATA;
            rcnt_d = 4'h0;
            rbit_d = 3'h0;
          end
        end
      end
      SER_DATA: begin
        if (tick16) begin
          rcnt_d = rcnt_q + 4'h1;
          if (rcnt_q == 4'hF) begin
            rsh_d = {rx_src, rsh_q[7:1]};
            rbit_d = rbit_q + 3'h1;
            if (rbit_q == last_bit) rst_d = SER_STOP;
          end
        end
      end
      SER_STOP: begin
        if (tick16) begin
          rcnt_d = rcnt_q + 4'h1;
          if (rcnt_q == 4'hF) begin
            rdat_d = rsh_q >> (2'h3 - cfg.len);
            if (rfull_q && !rx_take) ovr_d = 1'b1;
            fre_d = fre_d | !rx_src;
            rfull_d = 1'b1;
            rst_d = SER_IDLE;
          end
        end
      end
      default: rst_d = SER_IDLE;
    endcase
    if (clr) begin
      tst_d = SER_IDLE;
      rst_d = SER_IDLE;
      hold_full_d = 1'b0;
      rfull_d = 1'b0;
      ovr_d = 1'b0;
      fre_d = 1'b0;
      line_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tst_q <= SER_IDLE;
      rst_q <= SER_IDLE;
      hold_q <= 8'h00;
      tsh_q <= 8'h00;
      rsh_q <= 8'h00;
      rdat_q <= 8'h00;
      hold_full_q <= 1'b0;
      line_q <= 1'b1;
      tcnt_q <= 4'h0;
      rcnt_q <= 4'h0;
      tbit_q <= 3'h0;
      rbit_q <= 3'h0;
      rfull_q <= 1'b0;
      ovr_q <= 1'b0;
      fre_q <= 1'b0;
    end else begin
      tst_q <= tst_d;
      rst_q <= rst_d;
      hold_q <= hold_d;
      tsh_q <= tsh_d;
      rsh_q <= rsh_d;
      rdat_q <= rdat_d;
      hold_full_q <= hold_full_d;
      line_q <= line_d;
      tcnt_q <= tcnt_d;
      rcnt_q <= rcnt_d;
      tbit_q <= tbit_d;
      rbit_q <= rbit_d;
      rfull_q <= rfull_d;
      ovr_q <= ovr_d;
      fre_q <= fre_d;
    end
  end

  always_comb begin
    serial_out = line_q;
    rx_byte = rdat_q;
    sts.frame_err = fre_q;
    sts.overrun = ovr_q;
    sts.tx_empty = (tst_q == SER_IDLE) && !hold_full_q;
    sts.tx_ready = !hold_full_q && cfg.tx_en;
    sts.rx_ready = rfull_q;
  end
endmodule

/* File: core/shbi_pkg.sv */
// shared constants and carrier types for the strobe host bus interface
package shbi_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD_DEFAULT = 9600;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned BAUD_DIV16 = CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE);

  // register addresses; channel registers repeat with address bit 3 set
  localparam logic [3:0] A_MODE_A = 4'h0;
  localparam logic [3:0] A_STCMD_A = 4'h1;
  localparam logic [3:0] A_CT_START = 4'h2;
  localparam logic [3:0] A_DATA_A = 4'h3;
  localparam logic [3:0] A_GPCFG_A = 4'h4;
  localparam logic [3:0] A_IRQ = 4'h5;
  localparam logic [3:0] A_OP_SET = 4'h6;
  localparam logic [3:0] A_OP_CLR = 4'h7;
  localparam logic [3:0] A_MODE_B = 4'h8;
  localparam logic [3:0] A_STCMD_B = 4'h9;
  localparam logic [3:0] A_CT_STOP = 4'hA;
  localparam logic [3:0] A_DATA_B = 4'hB;
  localparam logic [3:0] A_GPCFG_B = 4'hC;
  localparam logic [3:0] A_OPCFG = 4'hD;
  localparam logic [3:0] A_GPIN_A = 4'hE;
  localparam logic [3:0] A_GPIN_B = 4'hF;

  // reset values
  localparam logic [7:0] MR1_RST = 8'h03;
  localparam logic [7:0] MR2_RST = 8'h00;
  localparam logic [7:0] REG_CLR = 8'h00;
  localparam logic [7:0] OP_PINS_RST = 8'hFF;
  localparam logic [15:0] CT_RST = 16'h0000;

  // field positions
  localparam int unsigned MR1_LEN_LSB = 0;
  localparam int unsigned MR2_LOOP_BIT = 7;
  localparam int unsigned CMD_RX_EN = 0;
  localparam int unsigned CMD_RX_DIS = 1;
  localparam int unsigned CMD_TX_EN = 2;
  localparam int unsigned CMD_TX_DIS = 3;
  localparam int unsigned CMD_MISC_LSB = 4;
  localparam logic [2:0] CMD_MRPTR_RST = 3'h1;
  localparam logic [2:0] CMD_ERR_RST = 3'h4;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic loop;
    logic [1:0] len;
  } shbi_chan_cfg_t;

  typedef struct packed {
    logic frame_err;
    logic overrun;
    logic tx_empty;
    logic tx_ready;
    logic rx_ready;
  } shbi_chan_sts_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_START = 2'b01,
    SER_DATA = 2'b11,
    SER_STOP = 2'b10
  } shbi_ser_state_t;
endpackage

/* File: core/shbi_top.sv */
// strobe-style host bus port with two serial channels and pin logic
// What this block does
// - bus-style select high picks separate read/write strobes and chip select
// - eight-bit bidirectional data bus, bit 0 least significant
// - act only while chip select low; else data lines not driven
// - write loads addressed register, captured on write strobe rising edge
// - read drives addressed register, read begins at read strobe fall
// - four address inputs select the register or port accessed
// - reset high clears status, irq mask/status, out port registers
// - reset drives all out port bits high and stops the timer
// - reset idles both channels with serial outputs at mark
// - reset points mode register access at the first mode register
// - open-drain irq request pulled low while any masked condition true
// - receivers take data lsb first, high mark, low space
// - transmitters send data lsb first, high mark, low space
// - serial output held at mark when idle or looped back; a frame under way still finishes after disable
// - config register sets direction of each gp pin; each pin's function is fixed
// - every gp pin has change detection and input always active
`timescale 1ns/1ps
module shbi_top
  import shbi_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV16
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_level,
  input wire logic bus_style_sel,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] address,
  input wire logic [7:0] data_bus_sample,
  output logic [7:0] data_bus_drive,
  output logic data_bus_oe,
  output logic irq_request_n_drive,
  output logic irq_request_n_oe,
  input wire logic chan_a_serial_in,
  input wire logic chan_b_serial_in,
  output logic chan_a_serial_out,
  output logic chan_b_serial_out,
  input wire logic [7:0] gp_a_sample,
  output logic [7:0] gp_a_drive,
  output logic [7:0] gp_a_oe,
  input wire logic [7:0] gp_b_sample,
  output logic [7:0] gp_b_drive,
  output logic [7:0] gp_b_oe,
  output logic [7:0] out_port_bits
);
  if (BAUD_DIV < 1 || BAUD_DIV > 65535) begin : g_chk
    $error("BAUD_DIV must lie in 1..65535");
  end

  logic [15:0] div_q, div_d;
  logic tick16;
  always_comb begin
    tick16 = (div_q == 16'(BAUD_DIV - 1));
    div_d = tick16 ? 16'h0000 : div_q + 16'h0001;
  end

  // bus front end
  logic sel, rd_n_q, rd_n_d, wr_act_q, wr_act_d, rd_fall, wr_rise;
  logic [3:0] wadr_q, wadr_d;
  logic [7:0] wdat_q, wdat_d;
  always_comb begin
    sel = bus_style_sel && !chip_select_n;
    rd_n_d = read_strobe_n || !sel;
    rd_fall = sel && !read_strobe_n && rd_n_q;
    wr_act_d = sel && !write_strobe_n && read_strobe_n;
    wadr_d = wr_act_d ? address : wadr_q;
    wdat_d = wr_act_d ? data_bus_sample : wdat_q;
    wr_rise = wr_act_q && write_strobe_n;
    data_bus_oe = sel && !read_strobe_n;
  end

  // register state
  logic [7:0] mr1_q [2], mr1_d [2], mr2_q [2], mr2_d [2];
  logic [7:0] gpcfg_q [2], gpcfg_d [2], cos_q [2], cos_d [2];
  logic [7:0] gprev_q [2], gprev_d [2], gpdrv_q [2], gpdrv_d [2];
  logic mrptr_q [2], mrptr_d [2], rxen_q [2], rxen_d [2];
  logic txen_q [2], txen_d [2];
  logic [7:0] imr_q, imr_d, opr_q, opr_d, out_port_config_reg_q, out_port_config_reg_d;
  logic [7:0] rdat_q, rdat_d, op_q, op_d, irq_status_reg;
  logic [15:0] ct_q, ct_d;
  logic ct_run_q, ct_run_d, ct_flag_q, ct_flag_d;
  logic [7:0] gp_sample [2], rx_byte [2], sr [2];
  logic tx_load [2], rx_take [2], err_clr [2], ser_in [2], ser_out [2];
  shbi_chan_cfg_t cfg [2];
  shbi_chan_sts_t sts [2];
  logic c;

  always_comb begin
    gp_sample[0] = gp_a_sample;
    gp_sample[1] = gp_b_sample;
    ser_in[0] = chan_a_serial_in;
    ser_in[1] = chan_b_serial_in;
    for (int i = 0; i < 2; i++) begin
      cfg[i].rx_en = rxen_q[i];
      cfg[i].tx_en = txen_q[i];
      cfg[i].loop = mr2_q[i][MR2_LOOP_BIT];
      cfg[i].len = mr1_q[i][MR1_LEN_LSB +: 2];
      sr[i] = {1'b0, sts[i].frame_err, 1'b0, sts[i].overrun,
               sts[i].tx_empty, sts[i].tx_ready, 1'b0, sts[i].rx_ready};
    end
    irq_status_reg = {1'b0, |cos_q[1], sts[1].rx_ready, sts[1].tx_ready,
           ct_flag_q, |cos_q[0], sts[0].rx_ready, sts[0].tx_ready};
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    shbi_chan u_chan (
      .clk(clk),
      .nrst(nrst),
      .clr(reset_level),
      .tick16(tick16),
      .cfg(cfg[g]),
      .tx_load(tx_load[g]),
      .tx_byte(wdat_q),
      .rx_take(rx_take[g]),
      .err_clr(err_clr[g]),
      .serial_in(ser_in[g]),
      .serial_out(ser_out[g]),
      .sts(sts[g]),
      .rx_byte(rx_byte[g])
    );
  end

  always_comb begin
    mr1_d = mr1_q;
    mr2_d = mr2_q;
    mrptr_d = mrptr_q;
    rxen_d = rxen_q;
    txen_d = txen_q;
    gpcfg_d = gpcfg_q;
    gprev_d = gp_sample;
    imr_d = imr_q;
    opr_d = opr_q;
    out_port_config_reg_d = out_port_config_reg_q;
    rdat_d = rdat_q;
    ct_run_d = ct_run_q;
    ct_d = ct_q;
    ct_flag_d = ct_flag_q;
    for (int i = 0; i < 2; i++) begin
      tx_load[i] = 1'b0;
      rx_take[i] = 1'b0;
      err_clr[i] = 1'b0;
      cos_d[i] = cos_q[i];
    end
    c = 1'b0;
    if (ct_run_q && tick16) begin
      ct_d = ct_q - 16'h0001;
    end
    if (wr_rise) begin
      c = wadr_q[3];
      case (wadr_q)
        A_MODE_A, A_MODE_B: begin
          if (mrptr_q[c]) mr2_d[c] = wdat_q;
          else mr1_d[c] = wdat_q;
          mrptr_d[c] = 1'b1;
        end
        A_STCMD_A, A_STCMD_B: begin
          if (wdat_q[CMD_RX_EN]) rxen_d[c] = 1'b1;
          if (wdat_q[CMD_RX_DIS]) rxen_d[c] = 1'b0;
          if (wdat_q[CMD_TX_EN]) txen_d[c] = 1'b1;
          if (wdat_q[CMD_TX_DIS]) txen_d[c] = 1'b0;
          if (wdat_q[CMD_MISC_LSB +: 3] == CMD_MRPTR_RST)
            mrptr_d[c] = 1'b0;
          err_clr[c] = (wdat_q[CMD_MISC_LSB +: 3] == CMD_ERR_RST);
        end
        A_DATA_A, A_DATA_B: tx_load[c] = sts[c].tx_ready;
        A_GPCFG_A, A_GPCFG_B: gpcfg_d[c] = wdat_q;
        A_CT_START: begin
          ct_d = {wdat_q, 8'h00};
          ct_run_d = 1'b1;
        end
        A_CT_STOP: begin
          ct_run_d = 1'b0;
          ct_flag_d = 1'b0;
        end
        A_IRQ: imr_d = wdat_q;
        A_OP_SET: opr_d = opr_q | wdat_q;
        A_OP_CLR: opr_d = opr_q & ~wdat_q;
        A_OPCFG: out_port_config_reg_d = wdat_q;
        default: c = 1'b0;
      endcase
    end
    if (rd_fall) begin
      c = address[3];
      case (address)
        A_MODE_A, A_MODE_B: begin
          rdat_d = mrptr_q[c] ? mr2_q[c] : mr1_q[c];
          mrptr_d[c] = 1'b1;
        end
        A_STCMD_A, A_STCMD_B: rdat_d = sr[c];
        A_DATA_A, A_DATA_B: begin
          rdat_d = rx_byte[c];
          rx_take[c] = 1'b1;
        end
        A_GPCFG_A, A_GPCFG_B: rdat_d = gpcfg_q[c];
        A_CT_START: rdat_d = ct_q[15:8];
        A_CT_STOP: rdat_d = ct_q[7:0];
        A_IRQ: rdat_d = irq_status_reg;
        A_OP_SET, A_OP_CLR: rdat_d = opr_q;
        A_OPCFG: rdat_d = out_port_config_reg_q;
        A_GPIN_A, A_GPIN_B: begin
          rdat_d = gp_sample[address[0]];
          cos_d[address[0]] = 8'h00;
        end
        default: rdat_d = 8'h00;
      endcase
    end
    // a change in the same cycle as the clearing read is kept
    for (int i = 0; i < 2; i++) begin
      cos_d[i] = cos_d[i] | (gp_sample[i] ^ gprev_q[i]);
    end
    // a wrap in the cycle of a stop write still raises the flag
    if (ct_run_q && tick16 && ct_q == 16'h0000) ct_flag_d = 1'b1;
    if (reset_level) begin
      for (int i = 0; i < 2; i++) begin
        rxen_d[i] = 1'b0;
        txen_d[i] = 1'b0;
        mrptr_d[i] = 1'b0;
        cos_d[i] = REG_CLR;
        err_clr[i] = 1'b1;
        tx_load[i] = 1'b0;
      end
      imr_d = REG_CLR;
      opr_d = REG_CLR;
      out_port_config_reg_d = REG_CLR;
      ct_run_d = 1'b0;
      ct_flag_d = 1'b0;
    end
  end

  // pin drivers, registered
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // pin0 request-to-send, pin1 16x clock, pin2/3 irq levels
      gpdrv_d[i] = {~opr_q[7:4], ~sts[i].tx_ready, ~sts[i].rx_ready,
                    tick16, ~opr_q[i]};
    end
    for (int j = 0; j < 8; j++) begin
      op_d[j] = out_port_config_reg_q[j] ? ~irq_status_reg[j] : ~opr_q[j];
    end
    // pins go high at the reset edge itself, not one cycle later
    if (reset_level) op_d = OP_PINS_RST;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_q <= 16'h0000;
      rd_n_q <= 1'b1;
      wr_act_q <= 1'b0;
      wadr_q <= 4'h0;
      wdat_q <= 8'h00;
      for (int i = 0; i < 2; i++) begin
        mr1_q[i] <= MR1_RST;
        mr2_q[i] <= MR2_RST;
        mrptr_q[i] <= 1'b0;
        rxen_q[i] <= 1'b0;
        txen_q[i] <= 1'b0;
        gpcfg_q[i] <= REG_CLR;
        cos_q[i] <= REG_CLR;
        gprev_q[i] <= REG_CLR;
        gpdrv_q[i] <= OP_PINS_RST;
      end
      imr_q <= REG_CLR;
      opr_q <= REG_CLR;
      out_port_config_reg_q <= REG_CLR;
      rdat_q <= 8'h00;
      op_q <= OP_PINS_RST;
      ct_q <= CT_RST;
      ct_run_q <= 1'b0;
      ct_flag_q <= 1'b0;
    end else begin
      div_q <= div_d;
      rd_n_q <= rd_n_d;
      wr_act_q <= wr_act_d;
      wadr_q <= wadr_d;
      wdat_q <= wdat_d;
      mr1_q <= mr1_d;
      mr2_q <= mr2_d;
      mrptr_q <= mrptr_d;
      rxen_q <= rxen_d;
      txen_q <= txen_d;
      gpcfg_q <= gpcfg_d;
      cos_q <= cos_d;
      gprev_q <= gprev_d;
      gpdrv_q <= gpdrv_d;
      imr_q <= imr_d;
      opr_q <= opr_d;
      out_port_config_reg_q <= out_port_config_reg_d;
      rdat_q <= rdat_d;
      op_q <= op_d;
      ct_q <= ct_d;
      ct_run_q <= ct_run_d;
      ct_flag_q <= ct_flag_d;
    end
  end

  always_comb begin
    data_bus_drive = rdat_q;
    irq_request_n_drive = 1'b0;
    irq_request_n_oe = |(irq_status_reg & imr_q);
    chan_a_serial_out = ser_out[0];
    chan_b_serial_out = ser_out[1];
    gp_a_drive = gpdrv_q[0];
    gp_b_drive = gpdrv_q[1];
    gp_a_oe = gpcfg_q[0];
    gp_b_oe = gpcfg_q[1];
    out_port_bits = op_q;
  end
endmodule

/* File: testbench/shbi_host.sv */
// host cpu model driving the strobed bus
`timescale 1ns/1ps
module shbi_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic dev_oe,
  input wire logic [7:0] dev_d,
  output logic [7:0] bus,
  output logic [7:0] rdata,
  output logic done,
  output logic rvalid,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic [3:0] a
);
  logic [1:0] st;
  logic hoe;
  logic [7:0] hd;
  logic [7:0] last = 8'h5A;
  // a released bus flips every cycle
  assign bus = dev_oe ? dev_d : (hoe ? hd : ~last);
  always @(posedge clk) last <= bus;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= 2'h0;
      cs_n <= 1'h1;
      rd_n <= 1'h1;
      wr_n <= 1'h1;
      hoe <= 1'h0;
      done <= 1'h0;
    end else begin
      done <= (st == 2'h2);
      case (st)
        2'h0: if (go) begin
          cs_n <= 1'h0;
          a <= addr;
          hd <= wdata;
          hoe <= we;
          rd_n <= we;
          wr_n <= !we;
          rvalid <= !we;
          st <= 2'h1;
        end
        2'h1: st <= 2'h2;
        2'h2: begin
          rd_n <= 1'h1;
          wr_n <= 1'h1;
          rdata <= bus;
          st <= 2'h3;
        end
        default: begin
          cs_n <= 1'h1;
          hoe <= 1'h0;
          st <= 2'h0;
        end
      endcase
    end
  end
endmodule

/* File: testbench/shbi_top_asserts.sv */
// pin-level assertions for the strobe host port
`timescale 1ns/1ps
module shbi_top_asserts
  import shbi_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV16
)(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_level,
  input wire logic bus_style_sel,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_bus_drive,
  input wire logic data_bus_oe,
  input wire logic irq_request_n_drive,
  input wire logic irq_request_n_oe,
  input wire logic chan_a_serial_out,
  input wire logic chan_b_serial_out,
  input wire logic [7:0] gp_a_oe,
  input wire logic [7:0] out_port_bits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_style; !bus_style_sel |-> !data_bus_oe; endproperty
  a_style: assert property (p_style) else $error("bus driven");
  property p_oe_cs; data_bus_oe |-> !chip_select_n; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("bus unselected");
  property p_oe_rd;
    bus_style_sel && !chip_select_n && !read_strobe_n |-> data_bus_oe;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("read not driven");
  property p_rd_hold;
    read_strobe_n && $past(read_strobe_n) |-> $stable(data_bus_drive);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_wr_cfg;
    $changed(gp_a_oe) |-> !$past(write_strobe_n) || !$past(write_strobe_n, 2);
  endproperty
  a_wr_cfg: assert property (p_wr_cfg) else $error("config w/o write");
  property p_rst_op; reset_level |=> out_port_bits == 8'hFF; endproperty
  a_rst_op: assert property (p_rst_op) else $error("out port not high");
  property p_rst_tx;
    reset_level |=> chan_a_serial_out && chan_b_serial_out;
  endproperty
  a_rst_tx: assert property (p_rst_tx) else $error("serial not mark");
  property p_rst_irq; reset_level |=> !irq_request_n_oe; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
  property p_od; irq_request_n_oe |-> !irq_request_n_drive; endproperty
  a_od: assert property (p_od) else $error("irq pin driven high");
  c_read: cover property (!chip_select_n && !read_strobe_n);
  c_write: cover property ($rose(write_strobe_n) && !chip_select_n);
  c_irq: cover property (irq_request_n_oe);
endmodule

bind shbi_top shbi_top_asserts #(.BAUD_DIV(BAUD_DIV)) u_chk (
  .clk, .nrst, .reset_level, .bus_style_sel, .chip_select_n,
  .read_strobe_n, .write_strobe_n, .data_bus_drive, .data_bus_oe,
  .irq_request_n_drive, .irq_request_n_oe, .chan_a_serial_out,
  .chan_b_serial_out, .gp_a_oe, .out_port_bits
);

/* File: testbench/shbi_top_tb.sv */
// self-checking bench for the strobe host port
`timescale 1ns/1ps
module shbi_top_tb;
  import shbi_pkg::*;
  localparam int unsigned BD = 2;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic rst_lvl = 1'h0;
  logic sel = 1'h1;
  logic go = 1'h0;
  logic we = 1'h0;
  logic rx_a = 1'h1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] gp_ext = 8'h00;
  logic [31:0] seed = 32'h8F03;
  logic [15:0] e;
  logic [15:0] rq[$];
  logic [7:0] tq[$];
  int n_mismatch = 0;
  int check_count = 0;
  wire [7:0] bus, rdata, drv, gpa_d, gpa_oe, gpb_d, gpb_oe, opb;
  wire [3:0] a;
  wire done, rvalid, cs_n, rd_n, wr_n, oe, irq_d, irq_oe, tx_a, tx_b;

  shbi_top #(.BAUD_DIV(BD)) dut (
    .clk(clk), .nrst(nrst), .reset_level(rst_lvl), .bus_style_sel(sel),
    .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .address(a), .data_bus_sample(bus), .data_bus_drive(drv),
    .data_bus_oe(oe), .irq_request_n_drive(irq_d),
    .irq_request_n_oe(irq_oe), .chan_a_serial_in(rx_a),
    .chan_b_serial_in(1'h1), .chan_a_serial_out(tx_a),
    .chan_b_serial_out(tx_b), .gp_a_drive(gpa_d), .gp_a_oe(gpa_oe),
    .gp_a_sample((gpa_oe & gpa_d) | (~gpa_oe & gp_ext)),
    .gp_b_sample((gpb_oe & gpb_d) | (~gpb_oe & ~gp_ext)),
    .gp_b_drive(gpb_d), .gp_b_oe(gpb_oe), .out_port_bits(opb)
  );
  shbi_host host (
    .clk(clk), .nrst(nrst), .go(go), .we(we), .addr(addr), .wdata(wdata),
    .dev_oe(oe), .dev_d(drv), .bus(bus), .rdata(rdata), .done(done),
    .rvalid(rvalid), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a(a)
  );

  initial forever #20 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = xorshift(seed);
    v = seed[7:0];
  endtask

  task automatic acc(input logic w, input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    go <= 1'h1;
    we <= w;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    go <= 1'h0;
    for (int n = 0; n < 20 && done !== 1'h1; n++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask

  task automatic rd(input logic [3:0] ad, input logic [7:0] m,
                    input logic [7:0] v);
    rq.push_back({m, v});
    acc(1'h0, ad, 8'h00);
  endtask

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_a <= f[i];
      repeat (16 * BD - 1) @(posedge clk);
    end
  endtask

  // compares each read against the oldest noted expectation
  always @(negedge clk) begin
    if (done === 1'h1 && rvalid === 1'h1 && rq.size() > 0) begin
      e = rq.pop_front();
      chk(rdata & e[15:8], e[7:0]);
    end
  end

  // samples each transmitted frame mid-bit
  initial begin : txmon
    logic [7:0] b;
    forever begin
      @(negedge tx_a);
      repeat (24 * BD) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        b[i] = tx_a;
        repeat (16 * BD) @(negedge clk);
      end
      if (tq.size() > 0) chk(b, tq.pop_front());
      else n_mismatch++;
    end
  end

  initial begin
    logic [7:0] v;
    logic [7:0] w;
    logic lo;
    repeat (8) @(posedge clk);
    nrst <= 1'h1;
    rnd(v);
    gp_ext <= v;
    repeat (2) @(negedge clk);
    chk(opb, 8'hFF);
    chk({6'h00, tx_a, tx_b}, 8'h03);
    chk(8'(irq_oe), 8'h00);
    chk(8'(oe), 8'h00);
    rd(A_GPIN_B, 8'hFF, ~v);
    rd(A_IRQ, 8'h40, 8'h00);
    @(posedge clk);
    gp_ext <= ~v;
    rd(A_IRQ, 8'h44, 8'h44);
    rnd(v);
    acc(1'h1, A_GPCFG_A, v);
    chk(gpa_oe, v);
    rd(A_GPCFG_A, 8'hFF, v);
    @(posedge clk);
    sel <= 1'h0;
    acc(1'h1, A_GPCFG_A, ~v);
    chk(gpa_oe, v);
    @(posedge clk);
    sel <= 1'h1;
    rnd(w);
    acc(1'h1, A_OP_SET, w);
    chk(opb, ~w);
    chk(gpa_d & 8'hFD, {~w[7:4], 3'h6, ~w[0]});
    chk(gpb_d & 8'hF1, {~w[7:4], 3'h0, ~w[1]});
    rd(A_OP_SET, 8'hFF, w);
    rnd(v);
    acc(1'h1, A_OP_CLR, v);
    rd(A_OP_CLR, 8'hFF, w & ~v);
    rnd(v);
    rnd(w);
    acc(1'h1, A_MODE_B, v);
    acc(1'h1, A_MODE_B, w);
    acc(1'h1, A_STCMD_B, {1'h0, CMD_MRPTR_RST, 4'h0});
    rd(A_MODE_B, 8'hFF, v);
    rd(A_MODE_B, 8'hFF, w);
    @(posedge clk);
    rst_lvl <= 1'h1;
    @(posedge clk);
    rst_lvl <= 1'h0;
    repeat (2) @(negedge clk);
    chk(opb, 8'hFF);
    rd(A_OP_SET, 8'hFF, 8'h00);
    rd(A_STCMD_A, 8'h51, 8'h00);
    rd(A_MODE_B, 8'hFF, v);
    acc(1'h1, A_STCMD_A, 8'h05);
    acc(1'h1, A_IRQ, 8'h02);
    rnd(v);
    tq.push_back(v);
    acc(1'h1, A_DATA_A, v);
    rnd(w);
    send(w);
    @(negedge clk);
    chk(8'(irq_oe), 8'h01);
    rd(A_STCMD_A, 8'h01, 8'h01);
    rd(A_IRQ, 8'h02, 8'h02);
    rd(A_DATA_A, 8'hFF, w);
    chk(8'(irq_oe), 8'h00);
    acc(1'h1, A_MODE_A, MR1_RST);
    acc(1'h1, A_MODE_A, 8'h80);
    rnd(v);
    acc(1'h1, A_DATA_A, v);
    lo = 1'h0;
    repeat (24 * 16 * BD) begin
      @(negedge clk);
      lo = lo | !tx_a;
    end
    chk(8'(lo), 8'h00);
    rd(A_DATA_A, 8'hFF, v);
    chk(8'(rq.size()), 8'h00);
    chk(8'(tq.size()), 8'h00);
    stop_test();
  end
endmodule
